/* acsf_sample_fifo.sv */
// Acceleration sample buffer with output data and filter configuration
`timescale 1ns/1ps
module acsf_sample_fifo
   import acsf_pkg::*;
#(
   parameter int unsigned BASE_TICK_CYCLES =
      `ACSF_BASE_PERIOD_US * `ACSF_CLK_MHZ
)
(
   // Clock, reset, enable
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // Register port
   input  wire logic         regWrEn,
   input  wire logic         regRdEn,
   input  wire logic [7:0]   regAddr,
   input  wire logic [7:0]   regWrData,
   input  wire logic         regBurstCont,
   input  wire logic         regBurstEnd,
   output logic [7:0]        regRdData,
   // System mode from main_control_reg and sleep logic
   input  wire logic         activeMode,
   input  wire logic         hybridMode,
   input  wire logic         sleepActive,
   input  wire logic [2:0]   activeRateField,
   input  wire logic [1:0]   sleepRateField,
   input  wire logic [1:0]   lowNoiseLowPower,
   input  wire logic         fifoGate,
   input  wire logic         trigEvent,
   // Sample sources
   input  wire acsf_sample_t rawSample,
   input  wire acsf_sample_t hpfSample,
   // Status
   output logic [5:0]        bufCount,
   output logic              overflowFlag,
   output logic              watermarkFlag,
   output logic              gateError,
   output logic              triggeredFlag,
   // Filter and range controls
   output logic [1:0]        rangeSelect,
   output logic [9:0]        sensitivityUg,
   output logic              pulseUseHpf,
   output logic              pulseUseLpf,
   output logic [15:0]       hpCorner
);

   localparam logic [16:0] BASE_LAST = 17'(BASE_TICK_CYCLES - 1);
   localparam logic [5:0]  DEPTH     = 6'(`ACSF_DEPTH);

   acsf_state_s  st;
   acsf_state_s  next_st;
   acsf_sample_t headSample;
   acsf_sample_t pushData;
   logic         pushEn;
   logic [4:0]   pushIdx;

   // Rate exponent: period is the base period times two to this power
   function automatic logic [3:0] rate_exp(input logic [2:0] code);
      case (code)
         3'h0:    rate_exp = 4'h0;
         3'h1:    rate_exp = 4'h1;
         3'h2:    rate_exp = 4'h2;
         3'h3:    rate_exp = 4'h3;
         3'h4:    rate_exp = 4'h4;
         3'h5:    rate_exp = 4'h6;
         3'h6:    rate_exp = 4'h7;
         default: rate_exp = 4'h9;
      endcase
   endfunction : rate_exp

   // Corner shift for code 00 per power mode column and rate
   function automatic logic [3:0] corner_shift(input logic [1:0] pm,
                                               input logic [2:0] code);
      logic [3:0] e;
      e = rate_exp(code);
      case (pm)
         2'h0:    corner_shift = (e == 4'h0) ? 4'h0 :
                                 (e < 4'h4) ? 4'(e - 4'h1) : 4'h3;
         2'h1:    corner_shift = (e == 4'h0) ? 4'h0 : 4'(e - 4'h1);
         2'h2:    corner_shift = 4'h0;
         default: corner_shift = e;
      endcase
   endfunction : corner_shift

   function automatic logic [7:0] sample_byte(input acsf_sample_t s,
                                              input logic [2:0] idx);
      logic [13:0] ax;
      case (idx[2:1])
         2'h0:    ax = s[41:28];
         2'h1:    ax = s[27:14];
         default: ax = s[13:0];
      endcase
      // Left-justified 14-bit data
      sample_byte = idx[0] ? {ax[5:0], 2'h0} : ax[13:6];
   endfunction : sample_byte

   acsf_sample_store u_store (
      .clk    (clk),
      .rst_n  (rst_n),
      .ce     (ce),
      .wrEn   (pushEn),
      .wrIdx  (pushIdx),
      .wrData (pushData),
      .rdIdx  (st.head),
      .rdData (headSample)
   );

   always_comb begin
      logic        odrTick;
      logic        flush;
      logic        gateEnter;
      logic        sleepEdge;
      logic        popNow;
      logic        take;
      logic        headRead;
      logic        enabled;
      logic [3:0]  rExp;
      logic [10:0] multLast;
      logic [5:0]  cEff;
      logic [4:0]  headP;
      logic [5:0]  cap;
      logic [5:0]  preCap;
      logic [2:0]  idxAfter;
      logic [7:0]  rd;
      next_st   = st;
      odrTick   = 1'b0;
      flush     = 1'b0;
      popNow    = 1'b0;
      take      = 1'b0;
      headRead  = 1'b0;
      idxAfter  = st.byteIdx;
      rd        = 8'h00;
      pushEn    = 1'b0;
      pushIdx   = 5'h00;
      pushData  = st.curSample;
      enabled   = (st.mode != ACSF_OFF);

      next_st.activeQ = activeMode;
      next_st.sleepQ  = sleepActive;

      // Data period from the awake or sleep rate, doubled in hybrid
      rExp = sleepActive ? rate_exp({1'b1, sleepRateField})
                         : rate_exp(activeRateField);
      rExp = 4'(rExp + {3'h0, hybridMode});
      multLast = 11'((12'h001 << rExp) - 12'h001);
      if (!activeMode) begin
         next_st.baseCnt = 17'h00000;
         next_st.multCnt = 11'h000;
      end else if (st.baseCnt == BASE_LAST) begin
         next_st.baseCnt = 17'h00000;
         if (st.multCnt >= multLast) begin
            next_st.multCnt = 11'h000;
            odrTick         = 1'b1;
         end else begin
            next_st.multCnt = 11'(st.multCnt + 11'h001);
         end
      end else begin
         next_st.baseCnt = 17'(st.baseCnt + 17'h00001);
      end

      if (odrTick) begin
         next_st.curSample = st.hpfOut ? hpfSample : rawSample;
      end

      // Register writes
      if (regWrEn) begin
         case (regAddr)
            `ACSF_ADDR_SETUP: begin
               next_st.mode = acsf_mode_e'(regWrData[`ACSF_SETUP_MODE_LSB+:2]);
               next_st.wmrk = regWrData[`ACSF_SETUP_WMRK_LSB+:6];
            end
            `ACSF_ADDR_RANGE: begin
               next_st.hpfOut      = regWrData[`ACSF_RANGE_HPF_BIT];
               next_st.rangeSelect = regWrData[`ACSF_RANGE_FS_LSB+:2];
            end
            `ACSF_ADDR_CUTOFF: begin
               next_st.pulseByp = regWrData[`ACSF_CUT_BYP_BIT];
               next_st.pulseLpf = regWrData[`ACSF_CUT_LPF_BIT];
               next_st.cutSel   = regWrData[`ACSF_CUT_SEL_LSB+:2];
            end
            default: begin
            end
         endcase
      end

      // Register reads; with the buffer on, the data window streams the head
      if (regRdEn) begin
         case (regAddr)
            `ACSF_ADDR_SETUP:  rd = {st.mode, st.wmrk};
            `ACSF_ADDR_RANGE:  rd = {3'h0, st.hpfOut, 2'h0, st.rangeSelect};
            `ACSF_ADDR_CUTOFF: rd = {2'h0, st.pulseByp, st.pulseLpf, 2'h0,
                                     st.cutSel};
            default: begin
               if (regAddr >= `ACSF_ADDR_OUT_X_HI &&
                   regAddr <= `ACSF_ADDR_OUT_Z_LO) begin
                  if (!enabled) begin
                     rd = sample_byte(st.curSample,
                                      3'(regAddr - `ACSF_ADDR_OUT_X_HI));
                  end else if (regAddr == `ACSF_ADDR_OUT_X_HI ||
                               (regBurstCont && st.byteIdx != 3'h0)) begin
                     headRead = (st.count != 6'h00);
                     if (headRead) begin
                        rd = sample_byte(headSample, st.byteIdx);
                     end
                  end
               end
            end
         endcase
         next_st.rdData = rd;
      end

      // Sample consumed after its last byte or when its burst ends early
      if (headRead) begin
         idxAfter = 3'(st.byteIdx + 3'h1);
         if (idxAfter == 3'(`ACSF_BYTES_PER_SMP)) begin
            popNow   = 1'b1;
            idxAfter = 3'h0;
         end
      end
      if (regBurstEnd && idxAfter != 3'h0) begin
         popNow   = 1'b1;
         idxAfter = 3'h0;
      end
      next_st.byteIdx = idxAfter;

      // Flush sources; a gated sleep entry keeps the contents instead
      sleepEdge = activeMode && st.activeQ && (sleepActive != st.sleepQ);
      gateEnter = sleepEdge && sleepActive && fifoGate && enabled;
      flush = (next_st.mode == ACSF_OFF) ||
              (activeMode && !st.activeQ) ||
              (sleepEdge && !gateEnter);

      cEff  = 6'(st.count - {5'h00, popNow});
      headP = 5'(st.head + {4'h0, popNow});
      next_st.head  = headP;
      next_st.count = cEff;

      if (trigEvent && st.mode == ACSF_TRIG && activeMode) begin
         next_st.triggered = 1'b1;
      end
      preCap = (st.wmrk == 6'h00 || st.wmrk > DEPTH) ? DEPTH
                                                     : st.wmrk;
      cap = (st.mode == ACSF_TRIG && !st.triggered) ? preCap : DEPTH;

      // Acquisition continues past the watermark; the gate halts it, as does a full buffer in stop mode or after a trigger
      take = odrTick && enabled && !st.gateErr && !flush;
      if (take) begin
         pushData = st.hpfOut ? hpfSample : rawSample;
         if (cEff < cap) begin
            pushEn        = 1'b1;
            pushIdx       = 5'(headP + cEff[4:0]);
            next_st.count = 6'(cEff + 6'h01);
         end else if (st.mode == ACSF_CIRC ||
                      (st.mode == ACSF_TRIG && !st.triggered)) begin
            // Overwrite the oldest sample
            pushEn       = 1'b1;
            pushIdx      = 5'(headP + cEff[4:0]);
            next_st.head = 5'(headP + 5'h01);
         end
      end

      if (flush) begin
         next_st.head      = 5'h00;
         next_st.count     = 6'h00;
         next_st.byteIdx   = 3'h00;
         next_st.triggered = 1'b0;
         pushEn            = 1'b0;
      end
      if (next_st.mode == ACSF_OFF) begin
         next_st.ovf     = 1'b0;
         next_st.gateErr = 1'b0;
      end

      // Gate error ends once the host has emptied the buffer; set wins
      if (st.gateErr && next_st.count == 6'h00) begin
         next_st.gateErr = 1'b0;
      end
      if (gateEnter) begin
         next_st.gateErr = 1'b1;
      end
      if (next_st.count == DEPTH) begin
         next_st.ovf = 1'b1;
      end
      next_st.wmFlag = (st.wmrk != 6'h00) &&
                       (next_st.count >= st.wmrk);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st             <= '0;
         st.mode        <= acsf_mode_e'(
            2'(`ACSF_RST_SETUP >> `ACSF_SETUP_MODE_LSB));
         st.wmrk        <= 6'(`ACSF_RST_SETUP);
         st.hpfOut      <= 1'(`ACSF_RST_RANGE >> `ACSF_RANGE_HPF_BIT);
         st.rangeSelect <= 2'(`ACSF_RST_RANGE);
         st.pulseByp    <= 1'(`ACSF_RST_CUTOFF >> `ACSF_CUT_BYP_BIT);
         st.pulseLpf    <= 1'(`ACSF_RST_CUTOFF >> `ACSF_CUT_LPF_BIT);
         st.cutSel      <= 2'(`ACSF_RST_CUTOFF);
      end else if (ce) begin
         st <= next_st;
      end
   end

   // Corner tracks awake rate and power mode; hybrid halves the effective rate
   always_comb begin
      logic [4:0] sh;
      sh = 5'({1'b0, corner_shift(lowNoiseLowPower, activeRateField)} +
              {3'h0, st.cutSel} + {4'h0, hybridMode});
      hpCorner = `ACSF_CORNER_TOP >> sh;
   end

   always_comb begin
      case (st.rangeSelect)
         2'h0:    sensitivityUg = `ACSF_SENS_RANGE0;
         2'h1:    sensitivityUg = `ACSF_SENS_RANGE1;
         2'h2:    sensitivityUg = `ACSF_SENS_RANGE2;
         default: sensitivityUg = 10'h000;
      endcase
   end

   assign regRdData     = st.rdData;
   assign bufCount      = st.count;
   assign overflowFlag  = st.ovf;
   assign watermarkFlag = st.wmFlag;
   assign gateError     = st.gateErr;
   assign triggeredFlag = st.triggered;
   assign rangeSelect   = st.rangeSelect;
   assign pulseUseHpf   = !st.pulseByp;
   assign pulseUseLpf   = st.pulseLpf;

endmodule : acsf_sample_fifo

/* acsf_regs.svh */
// Register map, field positions, reset values and timing of the sample buffer
// Overview of operation
// - Mode field selects off, circular, stop, trigger
// - Flush on disable, sleep/wake change, activation
// - Writing off clears overflow, watermark, count
// - Overflow flag sets when count reaches 32
// - Watermark flag when count at least level
// - Level zero disables watermark flag
// - Trigger mode keeps level samples before trigger
// - Watermark never stops acquisition
// - One sample per data period, awake/sleep rate
// - Read returns oldest, removes it, count decrements
// - Partial burst drops rest of sample
// - Trigger: overwrite before, stop when full after
// - Output filter bit selects high-pass data
// - Range field selects sensitivity; code 11 reserved
// - Pulse bypass bit routes around high-pass
// - Pulse low-pass bit inserts low-pass filter
// - Cutoff select sets corner with awake rate, power mode
// - Hybrid halves rate and cutoff
// - Buffer on: head at first address, others zero
// - Gate bit: sleep keeps contents, halts, flags
`ifndef ACSF_REGS_SVH
`define ACSF_REGS_SVH

`define ACSF_ADDR_OUT_X_HI   8'h01
`define ACSF_ADDR_OUT_Z_LO   8'h06
`define ACSF_ADDR_SETUP      8'h09
`define ACSF_ADDR_RANGE      8'h0e
`define ACSF_ADDR_CUTOFF     8'h0f

`define ACSF_RST_SETUP       8'h00
`define ACSF_RST_RANGE       8'h00
`define ACSF_RST_CUTOFF      8'h00

`define ACSF_SETUP_MODE_LSB  6
`define ACSF_SETUP_WMRK_LSB  0
`define ACSF_RANGE_HPF_BIT   4
`define ACSF_RANGE_FS_LSB    0
`define ACSF_CUT_BYP_BIT     5
`define ACSF_CUT_LPF_BIT     4
`define ACSF_CUT_SEL_LSB     0

`define ACSF_DEPTH           32
`define ACSF_AXIS_W          14
`define ACSF_SAMPLE_W        42
`define ACSF_BYTES_PER_SMP   6

// Sensitivity in micro-g per LSB
`define ACSF_SENS_RANGE0     10'h0f4
`define ACSF_SENS_RANGE1     10'h1e8
`define ACSF_SENS_RANGE2     10'h3d0
// Corner at the top rate, code 00, in 1/256 Hz (16 Hz)
`define ACSF_CORNER_TOP      16'h1000

`define ACSF_CLK_MHZ         100
`define ACSF_BASE_PERIOD_US  1250

`endif

/* acsf_pkg.sv */
// Types shared by the sample buffer modules
package acsf_pkg;
`include "acsf_regs.svh"

   typedef enum logic [1:0] {
      ACSF_OFF  = 2'b00,
      ACSF_CIRC = 2'b01,
      ACSF_STOP = 2'b10,
      ACSF_TRIG = 2'b11
   } acsf_mode_e;

   typedef logic [`ACSF_SAMPLE_W-1:0] acsf_sample_t;

   typedef struct packed {
      acsf_sample_t [`ACSF_DEPTH-1:0] mem;
   } acsf_store_s;

   typedef struct packed {
      acsf_mode_e   mode;
      logic [5:0]   wmrk;
      logic         hpfOut;
      logic [1:0]   rangeSelect;
      logic         pulseByp;
      logic         pulseLpf;
      logic [1:0]   cutSel;
      logic [4:0]   head;
      logic [5:0]   count;
      logic [2:0]   byteIdx;
      logic         ovf;
      logic         wmFlag;
      logic         triggered;
      logic         gateErr;
      logic         activeQ;
      logic         sleepQ;
      logic [16:0]  baseCnt;
      logic [10:0]  multCnt;
      acsf_sample_t curSample;
      logic [7:0]   rdData;
   } acsf_state_s;

endpackage : acsf_pkg

/* acsf_sample_store.sv */
// Flip-flop storage of the buffered samples, one write port, one read index
`timescale 1ns/1ps
module acsf_sample_store
   import acsf_pkg::*;
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // Write side
   input  wire logic         wrEn,
   input  wire logic [4:0]   wrIdx,
   input  wire acsf_sample_t wrData,
   // Read side
   input  wire logic [4:0]   rdIdx,
   output acsf_sample_t      rdData
);

   acsf_store_s st;
   acsf_store_s next_st;

   always_comb begin
      next_st = st;
      if (wrEn) begin
         next_st.mem[wrIdx] = wrData;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign rdData = st.mem[rdIdx];

endmodule : acsf_sample_store

/* acsf_fifo_chk_sva.sv */
// Concurrent checks on the sample buffer ports
`timescale 1ns/1ps
`include "acsf_regs.svh"
module acsf_fifo_chk
   import acsf_pkg::*;
#(
   parameter int unsigned BASE_TICK_CYCLES = 4
)
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       ce,
   // Register port
   input wire logic       regWrEn,
   input wire logic       regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regBurstCont,
   input wire logic [7:0] regRdData,
   // Status and controls
   input wire logic       activeMode,
   input wire logic [5:0] bufCount,
   input wire logic       overflowFlag,
   input wire logic       watermarkFlag,
   input wire logic [1:0] rangeSelect,
   input wire logic [9:0] sensitivityUg,
   input wire logic       pulseUseHpf,
   input wire logic       pulseUseLpf
);
   logic [1:0] modeQ;
   logic [5:0] wmrkQ;
   logic [7:0] wrDataQ;
   logic       setupWr;
   logic       cutWr;
   logic       rangeWr;
   assign setupWr = ce && regWrEn && regAddr == `ACSF_ADDR_SETUP;
   assign cutWr   = ce && regWrEn && regAddr == `ACSF_ADDR_CUTOFF;
   assign rangeWr = ce && regWrEn && regAddr == `ACSF_ADDR_RANGE;
   // Shadow of the setup field, which the design keeps internal
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         modeQ   <= 2'h0;
         wmrkQ   <= 6'h00;
         wrDataQ <= 8'h00;
      end else begin
         wrDataQ <= regWrData;
         if (setupWr) begin
            modeQ <= regWrData[7:6];
            wmrkQ <= regWrData[5:0];
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence offWrite;
      setupWr && regWrData[7:6] == 2'h0;
   endsequence
   sequence flushed;
      bufCount == 6'h00 && !overflowFlag && !watermarkFlag;
   endsequence
   sens_map_a: assert property (
      sensitivityUg == (rangeSelect == 2'h3 ? 10'h000 :
      `ACSF_SENS_RANGE0 << rangeSelect))
      else $error("sensitivity does not follow range");
   range_wr_a: assert property (rangeWr |=>
      rangeSelect == wrDataQ[1:0]) else $error("range write lost");
   pulse_path_a: assert property (cutWr |=>
      pulseUseHpf == !wrDataQ[5] && pulseUseLpf == wrDataQ[4])
      else $error("pulse path bits wrong");
   off_clear_a: assert property (offWrite |=> flushed)
      else $error("disable did not clear status");
   count_max_a: assert property (bufCount <= 6'h20)
      else $error("count above depth");
   ovf_full_a: assert property (bufCount == 6'h20 |->
      overflowFlag) else $error("overflow missing at full");
   wm_level_a: assert property ($changed(bufCount) |->
      watermarkFlag == (wmrkQ != 6'h00 && bufCount >= wmrkQ))
      else $error("watermark flag wrong");
   count_step_a: assert property (
      $changed(bufCount) && bufCount != 6'h00
      |-> bufCount == $past(bufCount) + 6'h01 ||
          bufCount == $past(bufCount) - 6'h01) else $error("count jumped");
   act_flush_a: assert property ($rose(activeMode) |=>
      bufCount == 6'h00) else $error("activation did not flush");
   head_only_a: assert property (ce && regRdEn && !regBurstCont &&
      modeQ != 2'h0 && regAddr inside {[8'h02:8'h06]} |=> regRdData == 8'h00)
      else $error("data register not zero");
endmodule : acsf_fifo_chk

/* acsf_host_model.sv */
// Host model issuing burst reads from the buffer head
`timescale 1ns/1ps
module acsf_host_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Command
   input  wire logic       start,
   input  wire logic [2:0] nBytes,
   // Read side
   output logic            regRdEn,
   output logic [7:0]      regAddr,
   output logic            regBurstCont,
   output logic            regBurstEnd
);
   logic [2:0] step;
   // Falling edge keeps every change half a cycle clear of sampling
   always @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step         <= 3'h0;
         regRdEn      <= 1'b0;
         regAddr      <= 8'h00;
         regBurstCont <= 1'b0;
         regBurstEnd  <= 1'b0;
      end else begin
         regRdEn      <= 1'b0;
         regBurstCont <= 1'b0;
         regBurstEnd  <= 1'b0;
         // Idle address toggles so a stale value is never trusted
         regAddr      <= ~regAddr;
         if (step != 3'h0 && step <= nBytes) begin
            regRdEn      <= 1'b1;
            regAddr      <= {5'h00, step};
            regBurstCont <= step != 3'h1;
            step         <= step + 3'h1;
         end else if (step != 3'h0) begin
            regBurstEnd <= 1'b1;
            step        <= 3'h0;
         end else if (start) begin
            step <= 3'h1;
         end
      end
   end
endmodule : acsf_host_model

/* acsf_testbench.sv */
// Self-checking bench for the sample buffer
`timescale 1ns/1ps
`include "acsf_regs.svh"
module testbench
   import acsf_pkg::*;
;
   logic clk, rst_n, regWrEn, regRdEn, tbRdEn, activeMode, hybridMode;
   logic sleepActive, fifoGate, trigEvent, hpfOn, hostGo, rdTook;
   logic hRdEn, hCont, hEnd, overflowFlag, watermarkFlag, gateError;
   logic triggeredFlag, pulseUseHpf, pulseUseLpf;
   logic [7:0]   tbAddr, regWrData, regAddr, regRdData, hAddr, fifoStatus;
   logic [2:0]   activeRateField, hostN;
   logic [1:0]   lowNoiseLowPower, rangeSelect, sleepRateField;
   logic [5:0]   bufCount, seenCnt;
   logic [9:0]   sensitivityUg;
   logic [15:0]  hpCorner;
   acsf_sample_t rawSample, hpfSample;
   acsf_sample_t smpQ[$];
   logic [7:0]   expQ[$];
   int           errors, n_checks;
   assign hpfSample = ~rawSample;
   assign regRdEn   = tbRdEn | hRdEn;
   assign regAddr   = hRdEn ? hAddr : tbAddr;
   assign fifoStatus = {bufCount, overflowFlag, watermarkFlag};
   acsf_sample_fifo #(.BASE_TICK_CYCLES(4)) acsf_sample_fifo_i (.clk, .rst_n,
      .ce(1'b1), .regWrEn, .regRdEn, .regAddr, .regWrData,
      .regBurstCont(hCont), .regBurstEnd(hEnd), .regRdData, .activeMode,
      .hybridMode, .sleepActive, .activeRateField, .sleepRateField,
      .lowNoiseLowPower, .fifoGate, .trigEvent, .rawSample, .hpfSample,
      .bufCount, .overflowFlag, .watermarkFlag, .gateError, .triggeredFlag,
      .rangeSelect, .sensitivityUg, .pulseUseHpf, .pulseUseLpf, .hpCorner);
   acsf_host_model acsf_host_model_i (.clk, .rst_n, .start(hostGo),
      .nBytes(hostN), .regRdEn(hRdEn), .regAddr(hAddr),
      .regBurstCont(hCont), .regBurstEnd(hEnd));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(string what, logic [47:0] seen, logic [47:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   function automatic logic [7:0] byteOf(acsf_sample_t s, int i);
      logic [13:0] ax;
      ax = 14'(s >> (14 * (2 - i / 2)));
      return (i % 2 == 0) ? ax[13:6] : {ax[5:0], 2'h0};
   endfunction : byteOf
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      tbAddr    <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(negedge clk);
      regWrEn <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      tbAddr <= a;
      tbRdEn <= 1'b1;
      expQ.push_back(e);
      @(negedge clk);
      tbRdEn <= 1'b0;
   endtask : rd
   // Notes each captured sample: the source only moves after a push
   task automatic fill(input logic [5:0] target);
      seenCnt = bufCount;
      repeat (600) begin
         @(negedge clk);
         if (bufCount !== seenCnt) begin
            smpQ.push_back(hpfOn ? hpfSample : rawSample);
            seenCnt = bufCount;
            rawSample <= 42'({$urandom, $urandom});
         end
         if (bufCount === target) break;
      end
   endtask : fill
   task automatic burst(input logic [2:0] n);
      acsf_sample_t s;
      s = smpQ.pop_front();
      for (int i = 0; i < n; i++) expQ.push_back(byteOf(s, i));
      hostN  <= n;
      hostGo <= 1'b1;
      @(negedge clk);
      hostGo <= 1'b0;
      repeat (n + 3) @(negedge clk);
   endtask : burst
   always @(posedge clk) rdTook <= regRdEn;
   always @(negedge clk) begin
      if (rdTook) check("read data", regRdData, expQ.pop_front());
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      complete_run();
   end
   initial begin
      {rst_n, regWrEn, tbRdEn, tbAddr, regWrData, activeMode} = '0;
      {hybridMode, sleepActive, fifoGate, trigEvent, hpfOn} = '0;
      {hostGo, hostN, activeRateField, lowNoiseLowPower, seenCnt} = '0;
      errors = 0;
      n_checks = 0;
      void'($urandom(49));
      rawSample = 42'({$urandom, $urandom});
      sleepRateField = 2'($urandom);
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      rd(`ACSF_ADDR_SETUP, `ACSF_RST_SETUP);
      rd(`ACSF_ADDR_RANGE, `ACSF_RST_RANGE);
      rd(`ACSF_ADDR_CUTOFF, `ACSF_RST_CUTOFF);
      wr(8'h2a, 8'hff);
      rd(8'h2a, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(`ACSF_ADDR_RANGE, 8'(c));
         rd(`ACSF_ADDR_RANGE, 8'(c));
         check("sens", sensitivityUg,
               c == 3 ? 10'h000 : 10'h0f4 << c);
      end
      for (int c = 0; c < 8; c++) begin
         hybridMode <= c[2];
         wr(`ACSF_ADDR_CUTOFF, {2'h0, c[0], c[1], 2'h0, c[1:0]});
         check("corner", hpCorner,
               16'h1000 >> (c % 4 + c / 4));
         check("pulse", {pulseUseHpf, pulseUseLpf},
               {!c[0], c[1]});
      end
      {hybridMode, activeRateField, lowNoiseLowPower} <= {1'b0, 3'h1, 2'h3};
      wr(`ACSF_ADDR_CUTOFF, 8'h00);
      check("corner lp", hpCorner, 16'h0800);
      {activeRateField, lowNoiseLowPower} <= '0;
      // Stop mode on filtered data, level 5, set up in standby
      hpfOn = 1'b1;
      wr(`ACSF_ADDR_RANGE, 8'h10);
      wr(`ACSF_ADDR_SETUP, 8'h85);
      activeMode <= 1'b1;
      fill(6'h20);
      repeat (20) @(negedge clk);
      check("full", fifoStatus, 8'h83);
      activeMode <= 1'b0;
      burst(3'h6);
      check("after burst", bufCount, 6'h1f);
      burst(3'h2);
      check("after partial", bufCount, 6'h1e);
      burst(3'h6);
      rd(8'h03, 8'h00);
      wr(`ACSF_ADDR_SETUP, 8'h00);
      check("off", fifoStatus, 8'h00);
      // Circular, level zero, then activation and sleep flushes
      hpfOn = 1'b0;
      wr(`ACSF_ADDR_RANGE, 8'h00);
      wr(`ACSF_ADDR_SETUP, 8'h40);
      activeMode <= 1'b1;
      fill(6'h20);
      repeat (20) @(negedge clk);
      check("circ", fifoStatus, 8'h82);
      activeMode <= 1'b0;
      @(negedge clk);
      activeMode <= 1'b1;
      repeat (2) @(negedge clk);
      check("wake flush", bufCount, 6'h00);
      fill(6'h03);
      sleepActive <= 1'b1;
      repeat (2) @(negedge clk);
      check("sleep flush", bufCount, 6'h00);
      {sleepActive, fifoGate} <= 2'h1;
      fill(6'h03);
      sleepActive <= 1'b1;
      repeat (200) @(negedge clk);
      check("gated", {gateError, bufCount}, {1'b1, 6'h03});
      {sleepActive, fifoGate, activeMode} <= '0;
      // Leave circular through off: enabled modes never switch directly
      wr(`ACSF_ADDR_SETUP, 8'h00);
      // Trigger mode keeping four samples before the event
      wr(`ACSF_ADDR_SETUP, 8'hc4);
      activeMode <= 1'b1;
      fill(6'h04);
      repeat (60) @(negedge clk);
      check("pre trig", {triggeredFlag, bufCount}, 7'h04);
      trigEvent <= 1'b1;
      @(negedge clk);
      trigEvent <= 1'b0;
      fill(6'h20);
      repeat (40) @(negedge clk);
      check("post trig", {triggeredFlag, bufCount}, 7'h60);
      complete_run();
   end
endmodule : testbench
bind acsf_sample_fifo acsf_fifo_chk #(.BASE_TICK_CYCLES(BASE_TICK_CYCLES))
   acsf_fifo_chk_i (.clk, .rst_n, .ce, .regWrEn, .regRdEn, .regAddr,
   .regWrData, .regBurstCont, .regRdData, .activeMode, .bufCount,
   .overflowFlag, .watermarkFlag, .rangeSelect, .sensitivityUg,
   .pulseUseHpf, .pulseUseLpf);
